// File: twu_pkg.sv
// constants, codes and register map of the two-wire slave receiver
// Contract
// (R1) after last sent byte acked by master: not addressed; start requested once bus free
// (R2) own address register bits 7:1 hold the slave address answered to
// (R3) own address register bit 0 enables answering the general call address
// (R4) software enables unit and ack_enable, clears begin and halt requests
// (R5) match address then direction bit: zero receives, one transmits
// (R6) own address plus write received sets job_flag with valid status code
// (R7) addressed after lost arbitration gives codes 0x68 own, 0x78 general call
// (R8) software masks prescaler bits to zero when reading status codes
// (R9) ack_enable cleared mid transfer returns not-acknowledge after next byte
// (R10) with ack_enable zero own address is not acknowledged, bus still watched
// (R11) in sleep, address still matched from bus clock when ack_enable set, then wake
// (R12) after wake-up scl held low until job_flag cleared by writing one
// (R13) while asleep the data register is not updated from the bus
// (R14) own address plus write acknowledged reports code 0x60
// (R15) general call acknowledged reports code 0x70
// (R16) software clears job_flag; next byte acked per ack_enable
// (R17) own-address data byte reports 0x80 on ack, 0x88 on not-ack
// (R18) general call data byte reports 0x90 on ack, 0x98 on not-ack
// (R19) status register holds code in upper bits, prescaler in low two bits
package twu_pkg;
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STAT   = 8'h04;
    localparam logic [7:0] A_DATA   = 8'h08;
    localparam logic [7:0] A_OWN    = 8'h0C;
    localparam logic [7:0] A_IST    = 8'h10;
    localparam logic [7:0] A_IMASK  = 8'h14;
    localparam int CB_FLAG = 7;
    localparam int CB_ACK  = 6;
    localparam int CB_STA  = 5;
    localparam int CB_STO  = 4;
    localparam int CB_EN   = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_RST  = 8'h00;
    localparam logic [6:0] GC_ADDR  = 7'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] C_OWN_W  = 8'h60;
    localparam logic [7:0] C_ARB_W  = 8'h68;
    localparam logic [7:0] C_GC     = 8'h70;
    localparam logic [7:0] C_ARB_GC = 8'h78;
    localparam logic [7:0] C_RX_ACK = 8'h80;
    localparam logic [7:0] C_RX_NAK = 8'h88;
    localparam logic [7:0] C_GC_ACK = 8'h90;
    localparam logic [7:0] C_GC_NAK = 8'h98;
    localparam logic [7:0] C_OWN_R  = 8'hA8;
    localparam logic [7:0] C_ARB_R  = 8'hB0;
    localparam logic [7:0] C_TX_ACK = 8'hB8;
    localparam logic [7:0] C_TX_NAK = 8'hC0;
    localparam logic [7:0] C_TX_END = 8'hC8;
    localparam logic [7:0] C_IDLE   = 8'hF8;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_ACK, S_MACK, S_HOLD} state_t;
endpackage

// File: i2c_slave_receiver.sv
// two-wire slave receiver with last-byte transmit, axi4-lite registers
`timescale 1ns/1ps
module i2c_slave_receiver (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic [7:0] awaddr,
    input  wire logic       wvalid,
    output logic            wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    output logic            bvalid,
    input  wire logic       bready,
    output logic [1:0]      bresp,
    input  wire logic       arvalid,
    output logic            arready,
    input  wire logic [7:0] araddr,
    output logic            rvalid,
    input  wire logic       rready,
    output logic [31:0]     rdata,
    output logic [1:0]      rresp,
    input  wire logic       scl_i,
    output logic            scl_oe_n,
    input  wire logic       sda_i,
    output logic            sda_oe_n,
    input  wire logic       sleep_mode,
    input  wire logic       arb_lost,
    output logic            wake,
    output logic            start_request,
    output logic            irq
);
    import twu_pkg::*;

    twu_pkg::state_t state_q, next_q;
    logic [7:0] ctrl_q, own_q, data_q, code_q, sh_q, tx_q;
    logic [1:0] presc_q, ist_q, imask_q;
    logic [3:0] cnt_q;
    logic [2:0] scl_s, sda_s;
    logic       gc_q, nak_q, last_q, mack_q, free_q;
    logic       aw_q, w_q;
    logic [7:0] wa_q;
    logic [31:0] wd_q;
    logic       wr_go, rd_go, sw_clr, hw_set;
    logic       rise, fall, start_c, stop_c;
    logic       own_hit, gc_hit;

    function automatic logic mapped(input logic [7:0] a);
        return a == A_CTRL || a == A_STAT || a == A_DATA || a == A_OWN || a == A_IST || a == A_IMASK;
    endfunction

    // two flops before use; third stage only for edge finding
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
        end
    end

    assign rise    = scl_s[1] && !scl_s[2];
    assign fall    = !scl_s[1] && scl_s[2];
    assign start_c = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
    assign stop_c  = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
    assign own_hit = sh_q[7:1] == own_q[7:1];                        // [R2]
    assign gc_hit  = sh_q[7:1] == GC_ADDR && own_q[0];               // [R3]

    // axi write: address and data taken in either order
    assign wr_go = aw_q && w_q && !bvalid;
    assign rd_go = arvalid && arready;
    assign sw_clr = wr_go && wa_q == A_CTRL && wd_q[CB_FLAG] && wstrb[0];
    assign hw_set = state_q != S_HOLD && fall && (state_q == S_ACK || state_q == S_MACK);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            wa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            bvalid <= 1'b0;
            bresp <= RESP_OK;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_q <= 1'b1;
                wa_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_q <= 1'b1;
                wd_q <= wdata;
            end
            if (wr_go)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= mapped(wa_q) ? RESP_OK : RESP_ERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    assign awready = !aw_q && !bvalid;
    assign wready  = !w_q && !bvalid;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OK;
        end
        else
        begin
            arready <= !rvalid && !arready && arvalid;
            if (rd_go)
            begin
                rvalid <= 1'b1;
                rresp <= mapped(araddr) ? RESP_OK : RESP_ERR;
                case (araddr)
                    A_CTRL:  rdata <= {24'h000000, ctrl_q};
                    A_STAT:  rdata <= {24'h000000, code_q[7:3], 1'b0, presc_q};   // [R19] [R8]
                    A_DATA:  rdata <= {24'h000000, data_q};
                    A_OWN:   rdata <= {24'h000000, own_q};
                    A_IST:   rdata <= {30'h00000000, ist_q};
                    A_IMASK: rdata <= {30'h00000000, imask_q};
                    default: rdata <= 32'h0000_0000;
                endcase
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    // control: job_flag set by hardware wins over the software clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ctrl_q <= CTRL_RST;
            own_q <= OWN_RST;
            presc_q <= 2'h0;
            imask_q <= 2'h0;
        end
        else
        begin
            if (wr_go && wstrb[0])
            begin
                if (wa_q == A_CTRL)
                    ctrl_q <= {ctrl_q[CB_FLAG], wd_q[6:0]};              // [R4]
                if (wa_q == A_OWN)
                    own_q <= wd_q[7:0];
                if (wa_q == A_STAT)
                    presc_q <= wd_q[1:0];
                if (wa_q == A_IMASK)
                    imask_q <= wd_q[1:0];
            end
            if (hw_set)
                ctrl_q[CB_FLAG] <= 1'b1;                                  // [R6]
            else if (sw_clr)
                ctrl_q[CB_FLAG] <= 1'b0;                                  // [R12] [R16]
            if (state_q == S_HOLD && !ctrl_q[CB_FLAG])
                ctrl_q[CB_STO] <= 1'b0;
        end
    end

    // interrupt status: bit0 job event, bit1 stop seen; read clears, set wins
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ist_q <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            ist_q <= (rd_go && araddr == A_IST ? 2'h0 : ist_q) | {stop_c, hw_set};
            irq <= |(ist_q & imask_q);
        end
    end

    // bus side state machine, sampled on the system clock
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= S_IDLE;
            next_q <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            data_q <= 8'h00;
            code_q <= C_IDLE;
            gc_q <= 1'b0;
            nak_q <= 1'b0;
            last_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_n <= 1'b1;
            wake <= 1'b0;
        end
        else
        begin
            wake <= 1'b0;
            if (!ctrl_q[CB_EN] || stop_c)
            begin
                state_q <= S_IDLE;
                sda_oe_n <= 1'b1;
                code_q <= C_IDLE;
            end
            else if (start_c)
            begin
                state_q <= S_ADDR;                                        // [R10]
                cnt_q <= 4'h0;
                sda_oe_n <= 1'b1;
            end
            else
                case (state_q)
                    S_ADDR, S_RX:
                        if (rise)
                        begin
                            sh_q <= {sh_q[6:0], sda_s[1]};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (fall && cnt_q == BYTE_BITS)
                        begin
                            if (state_q == S_RX)
                            begin
                                if (!sleep_mode)
                                    data_q <= sh_q;                       // [R13]
                                nak_q <= !ctrl_q[CB_ACK];                 // [R9] [R16]
                                sda_oe_n <= !ctrl_q[CB_ACK];
                                state_q <= S_ACK;
                                if (ctrl_q[CB_ACK])
                                    code_q <= gc_q ? C_GC_ACK : C_RX_ACK; // [R17] [R18]
                                else
                                    code_q <= gc_q ? C_GC_NAK : C_RX_NAK; // [R17] [R18]
                            end
                            else if (ctrl_q[CB_ACK] && (own_hit || gc_hit) && !(gc_hit && sh_q[0]))
                            begin
                                gc_q <= gc_hit && !own_hit;               // [R1] [R5]
                                nak_q <= 1'b0;
                                next_q <= sh_q[0] ? S_TX : S_RX;
                                sda_oe_n <= 1'b0;
                                wake <= sleep_mode;                       // [R11]
                                state_q <= S_ACK;
                                if (sh_q[0])
                                    code_q <= arb_lost ? C_ARB_R : C_OWN_R;
                                else if (gc_hit && !own_hit)
                                    code_q <= arb_lost ? C_ARB_GC : C_GC;   // [R15] [R7]
                                else
                                    code_q <= arb_lost ? C_ARB_W : C_OWN_W; // [R14] [R7]
                            end
                            else
                                state_q <= S_IDLE;                        // [R10]
                        end
                    S_ACK:
                        if (fall)
                        begin
                            sda_oe_n <= 1'b1;
                            state_q <= S_HOLD;
                            // a refused byte ends the transfer once software releases the flag
                            if (nak_q)
                                next_q <= S_IDLE;
                            cnt_q <= 4'h0;
                        end
                    S_TX:
                        if (rise)
                            cnt_q <= cnt_q + 4'h1;
                        else if (fall)
                        begin
                            if (cnt_q == BYTE_BITS)
                            begin
                                sda_oe_n <= 1'b1;
                                state_q <= S_MACK;
                            end
                            else
                            begin
                                sda_oe_n <= tx_q[7];
                                tx_q <= {tx_q[6:0], 1'b1};
                            end
                        end
                    S_MACK:
                        if (rise)
                            mack_q <= !sda_s[1];
                        else if (fall)
                        begin
                            state_q <= S_HOLD;
                            cnt_q <= 4'h0;
                            if (!mack_q)
                            begin
                                code_q <= C_TX_NAK;
                                next_q <= S_IDLE;
                            end
                            else if (last_q)
                            begin
                                code_q <= C_TX_END;                       // [R1]
                                next_q <= S_IDLE;
                            end
                            else
                                code_q <= C_TX_ACK;
                        end
                    S_HOLD:
                        if (!ctrl_q[CB_FLAG])
                        begin
                            state_q <= ctrl_q[CB_STO] ? S_IDLE : next_q;
                            if (next_q == S_TX)
                            begin
                                last_q <= !ctrl_q[CB_ACK];
                                sda_oe_n <= data_q[7];
                                tx_q <= {data_q[6:0], 1'b1};
                            end
                            if (next_q == S_IDLE)
                                code_q <= C_IDLE;
                        end
                    default:
                        state_q <= S_IDLE;
                endcase
        end
    end

    // clock stretch while job_flag waits for software; bus-free tracking
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            scl_oe_n <= 1'b1;
            free_q <= 1'b1;
            start_request <= 1'b0;
        end
        else
        begin
            scl_oe_n <= !(state_q == S_HOLD && ctrl_q[CB_FLAG] && !scl_s[1]);   // [R12]
            if (start_c)
                free_q <= 1'b0;
            else if (stop_c)
                free_q <= 1'b1;
            start_request <= ctrl_q[CB_EN] && ctrl_q[CB_STA] && free_q && state_q == S_IDLE;   // [R1]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_flag_on_addr: assert property (state_q == S_ACK && fall && !stop_c && !start_c && ctrl_q[CB_EN]
        |=> ctrl_q[CB_FLAG] && state_q == S_HOLD) else $error("job flag not set after ack");   // [R6]
    a_own_write_code: assert property (state_q == S_ADDR && fall && cnt_q == BYTE_BITS && ctrl_q[CB_ACK]
        && own_hit && !sh_q[0] && !arb_lost && !stop_c && !start_c && ctrl_q[CB_EN]
        |=> code_q == C_OWN_W) else $error("own write code wrong");   // [R14]
    a_gc_code: assert property (state_q == S_ADDR && fall && cnt_q == BYTE_BITS && ctrl_q[CB_ACK]
        && gc_hit && !own_hit && !sh_q[0] && !arb_lost && !stop_c && !start_c && ctrl_q[CB_EN]
        |=> code_q == C_GC) else $error("general call code wrong");   // [R15]
    a_no_ack_off: assert property (state_q == S_ADDR && fall && cnt_q == BYTE_BITS && !ctrl_q[CB_ACK]
        && !stop_c && !start_c |=> state_q == S_IDLE && sda_oe_n) else $error("address acked with ack off");   // [R10]
    a_data_nak: assert property (state_q == S_RX && fall && cnt_q == BYTE_BITS && !ctrl_q[CB_ACK]
        && !stop_c && !start_c && ctrl_q[CB_EN] |=> sda_oe_n ##1 1) else $error("nak not driven");   // [R9]
    a_scl_hold: assert property (state_q == S_HOLD && ctrl_q[CB_FLAG] && !scl_s[1] && $stable(state_q)
        |=> !scl_oe_n) else $error("scl not held low");   // [R12]
    a_sleep_data: assert property (sleep_mode |=> data_q == $past(data_q)) else $error("data changed in sleep");   // [R13]
    a_irq_level: assert property (ist_q == $past(ist_q) && imask_q == $past(imask_q)
        |-> irq == |(ist_q & imask_q)) else $error("irq level wrong");
    a_flag_set_wins: assert property (hw_set && sw_clr |=> ctrl_q[CB_FLAG]) else $error("clear beat set");   // [R6]
endmodule

// File: i2c_master_model.sv
// behavioural two-wire master transmitter on pulled-up bus lines
`timescale 1ns/1ps
module i2c_master_model (
    output logic      scl_m,
    output logic      sda_m,
    input  wire logic scl,
    input  wire logic sda
);
    logic stuck = 1'b0;
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // the slave may stretch the low phase: follow the wire, bounded
    task automatic rise();
        int n;
        scl_m = 1'b1;
        for (n = 0; n < 400 && scl !== 1'b1; n++)
            #40;
        if (n == 400)
            stuck = 1'b1;
    endtask
    // odd offset keeps link edges away from the system clock edges
    task automatic start();
        #7;
        rise();
        #80;
        sda_m = 1'b0;
        #160;
        scl_m = 1'b0;
        #80;
    endtask
    task automatic bit_out(input logic b);
        sda_m = b;
        #80;
        rise();
        #160;
        scl_m = 1'b0;
        #80;
    endtask
    // msb first, sda released in the ninth clock for the answer
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_out(b[i]);
        sda_m = 1'b1;
        #80;
        rise();
        #80;
        ack = (sda === 1'b0);
        #80;
        scl_m = 1'b0;
        #80;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #80;
        rise();
        #160;
        sda_m = 1'b1;
        #160;
    endtask
endmodule

// File: test_i2c_slave_receiver.sv
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
module test_i2c_slave_receiver;
    import twu_pkg::*;
    typedef struct packed {logic [7:0] own, adr; logic arb, ack; logic [7:0] code, dcode;} row_t;
    logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready, sleep_mode, arb_lost;
    logic        awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, wake, start_request, irq;
    logic        scl_m, sda_m, ack;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr;
    logic [31:0] rv;
    wire         scl = scl_m & scl_oe_n;
    wire         sda = sda_m & sda_oe_n;
    int          n_fail = 0, comparisons = 0, wakes = 0, w0, n;
    row_t        rows [6] = '{
        '{8'h84, 8'h84, 1'b0, 1'b1, C_OWN_W, C_RX_ACK},
        '{8'h85, 8'h00, 1'b0, 1'b1, C_GC, C_GC_ACK},
        '{8'h84, 8'h00, 1'b0, 1'b0, C_IDLE, C_IDLE},
        '{8'h84, 8'h84, 1'b1, 1'b1, C_ARB_W, C_RX_ACK},
        '{8'h85, 8'h00, 1'b1, 1'b1, C_ARB_GC, C_GC_ACK},
        '{8'hE6, 8'h84, 1'b0, 1'b0, C_IDLE, C_IDLE}};

    i2c_slave_receiver i_dut (
        .clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .scl_i(scl),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_oe_n(sda_oe_n), .sleep_mode(sleep_mode),
        .arb_lost(arb_lost), .wake(wake), .start_request(start_request), .irq(irq));
    i2c_master_model i_master (.scl_m(scl_m), .sda_m(sda_m), .scl(scl), .sda(sda));

    always #20 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic hang();
        n_fail++;
        give_verdict();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        int k;
        @(posedge clk);
        aw = 1'b1;
        w = 1'b1;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        bready <= 1'b1;
        for (k = 0; k < 40 && bvalid !== 1'b1; k++)
        begin
            @(posedge clk);
            if (aw && awready === 1'b1)
            begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1)
            begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (k == 40)
            hang();
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (k = 0; k < 40 && rvalid !== 1'b1; k++)
        begin
            @(posedge clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        if (k == 40)
            hang();
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  r;
        rd(a, v, r);
        chk(v & m, e);
        chk({30'h0, r}, {30'h0, RESP_OK});
    endtask

    initial
    begin
        {clk, resetn, awvalid, wvalid, bready, arvalid, rready, sleep_mode, arb_lost} = 9'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk({scl_oe_n, sda_oe_n, irq, start_request}, 4'hC);
        rchk(A_STAT, 32'hFF, 32'hF8);
        rchk(A_CTRL, 32'hFF, 32'h0);
        rchk(A_OWN, 32'hFF, 32'h0);
        wr(8'h18, 8'h55, RESP_ERR);
        rd(8'h18, rv, rr);
        chk(rv, 32'h0);
        chk({30'h0, rr}, {30'h0, RESP_ERR});
        wr(A_STAT, 8'h03, RESP_OK);
        rchk(A_STAT, 32'hFF, 32'hFB);
        wr(A_IMASK, 8'h01, RESP_OK);
        foreach (rows[i])
        begin
            wr(A_OWN, rows[i].own, RESP_OK);
            arb_lost <= rows[i].arb;
            wr(A_CTRL, 8'h44, RESP_OK);
            i_master.start();
            i_master.send(rows[i].adr, ack);
            chk_bit(ack, rows[i].ack);
            rchk(A_STAT, 32'hF8, {24'h0, rows[i].code});
            if (rows[i].ack)
            begin
                chk_bit(irq, 1'b1);
                rchk(A_IST, 32'h1, 32'h1);
                wr(A_CTRL, 8'hC4, RESP_OK);
                chk_bit(irq, 1'b0);
                i_master.send(8'hA5, ack);
                chk_bit(ack, 1'b1);
                rchk(A_STAT, 32'hF8, {24'h0, rows[i].dcode});
                rchk(A_DATA, 32'hFF, 32'hA5);
                wr(A_CTRL, 8'hC4, RESP_OK);
            end
            i_master.stop();
        end
        // masked event: no irq, but the status bit still records it
        wr(A_IMASK, 8'h00, RESP_OK);
        wr(A_OWN, 8'h84, RESP_OK);
        wr(A_CTRL, 8'h44, RESP_OK);
        i_master.start();
        i_master.send(8'h84, ack);
        wr(A_CTRL, 8'h84, RESP_OK);
        i_master.send(8'h3C, ack);
        chk_bit(ack, 1'b0);
        rchk(A_STAT, 32'hF8, {24'h0, C_RX_NAK});
        rchk(A_DATA, 32'hFF, 32'h3C);
        chk_bit(irq, 1'b0);
        rchk(A_IST, 32'h1, 32'h1);
        wr(A_CTRL, 8'h84, RESP_OK);
        i_master.stop();
        i_master.start();
        i_master.send(8'h84, ack);
        chk_bit(ack, 1'b0);
        i_master.stop();
        wr(A_IMASK, 8'h01, RESP_OK);
        wr(A_CTRL, 8'h44, RESP_OK);
        sleep_mode <= 1'b1;
        w0 = wakes;
        i_master.start();
        i_master.send(8'h84, ack);
        chk_bit(ack, 1'b1);
        chk(wakes - w0, 32'h1);
        repeat (20) @(posedge clk);
        chk_bit(scl_oe_n, 1'b0);
        sleep_mode <= 1'b0;
        wr(A_CTRL, 8'hC4, RESP_OK);
        for (n = 0; n < 20 && scl_oe_n !== 1'b1; n++)
            @(posedge clk);
        chk_bit(scl_oe_n, 1'b1);
        i_master.stop();
        wr(A_CTRL, 8'h64, RESP_OK);
        for (n = 0; n < 40 && start_request !== 1'b1; n++)
            @(posedge clk);
        chk_bit(start_request, 1'b1);
        chk_bit(i_master.stuck, 1'b0);
        give_verdict();
    end
endmodule
